// *** shared/ift_pkg.sv ***
// Package for the instruction format and timing block.
// Assumes one oscillator clock; the shared constants and carrier types live here, the sequencer state type in ift_core.
package ift_pkg;

    // ----------------------------------------------------------------
    // Word and field layout
    // ----------------------------------------------------------------
    localparam int WORD_W = 16;
    localparam logic [3:0] SECOND_WORD_TAG = 4'hF;
    localparam int OPC_LSB = 10;       // Byte-op opcode occupies [15:10]
    localparam int D_POS = 9;
    localparam int A_POS = 8;
    localparam int S_POS = 0;
    localparam int BIT_LSB = 9;        // Bit number occupies [11:9]
    localparam int MM_LSB = 0;         // Table mode occupies [1:0]
    localparam int FSR_LSB = 4;        // Pointer number occupies [5:4]

    // ----------------------------------------------------------------
    // Timing constants
    // ----------------------------------------------------------------
    localparam logic [1:0] PHASES_PER_CYCLE_M1 = 2'h3;
    localparam logic [1:0] PHASE_RESET = 2'h0;
    localparam logic [1:0] CYCLES_ONE = 2'h1;
    localparam logic [1:0] CYCLES_TWO = 2'h2;
    localparam logic [1:0] CYCLES_THREE = 2'h3;

    // Instruction category
    typedef enum logic [3:0] {
        IFT_CAT_BYTE = 4'h1,
        IFT_CAT_BIT = 4'h2,
        IFT_CAT_LIT = 4'h4,
        IFT_CAT_CTRL = 4'h8
    } ift_cat_t;

    // Table pointer update behaviour
    typedef enum logic [1:0] {
        IFT_TBL_NONE = 2'h0,
        IFT_TBL_POSTINC = 2'h1,
        IFT_TBL_POSTDEC = 2'h2,
        IFT_TBL_PREINC = 2'h3
    } ift_tbl_t;

    // Decoded fields of one instruction
    typedef struct packed {
        ift_cat_t category;
        logic [5:0] opcode;
        logic [7:0] file_sel;
        logic dest_to_file;
        logic use_bank_select;
        logic [2:0] bit_num;
        logic [11:0] literal;
        logic [1:0] file_select_pointer;
        logic fast_mode;
        ift_tbl_t table_pointer_mode;
        logic double_word;
        logic is_nop;
    } ift_fields_t;

    // Cycle timing status
    typedef struct packed {
        logic [1:0] phase;
        logic cycle_start;
        logic [1:0] cycles_total;
        logic [1:0] cycle_index;
        logic busy;
    } ift_timing_t;

endpackage : ift_pkg

// *** design/ift_core.sv ***
// Instruction word field decoder and instruction-cycle timing generator.
// Assumes instruction words and the taken/pc-change hints come from core logic
// on the same oscillator clock; no synchronisers are needed.
`timescale 1ns/100ps
module ift_core (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic clk_en_in,
    input wire logic word_valid_in,
    input wire logic [15:0] word_in,
    input wire logic cond_true_in,
    input wire logic pc_change_in,
    output ift_pkg::ift_fields_t fields_out,
    output ift_pkg::ift_timing_t timing_out,
    output logic [15:0] operand2_out,
    output logic shadow_use_out,
    output logic bank_select_use_out,
    output logic write_working_register_out
);
    import ift_pkg::*;

    // ----------------------------------------------------------------
    // Sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        IFT_ST_IDLE = 4'h1,
        IFT_ST_FIRST = 4'h2,
        IFT_ST_SECOND = 4'h4,
        IFT_ST_EXTRA = 4'h8
    } ift_state_t;

    // Classify one word by its top bits
    function automatic ift_cat_t classify(input logic [15:0] w);
        // Pointer load sits in the control nibble but is a literal operation
        if (w[15:6] == 10'h3B8) begin
            classify = IFT_CAT_LIT;
        end else if (w[15:12] == 4'hE || w[15:12] == 4'hD || w[15:8] == 8'h00) begin
            classify = IFT_CAT_CTRL;
        end else if (w[15:12] >= 4'h7 && w[15:12] <= 4'hB) begin
            classify = IFT_CAT_BIT;
        end else if (w[15:10] == 6'h3A || w[15:8] == 8'h0E || w[15:8] == 8'h0F) begin
            classify = IFT_CAT_LIT;
        end else begin
            classify = IFT_CAT_BYTE;
        end
    endfunction : classify

    // Double-word opcodes: file move, pointer load, call, goto
    function automatic logic is_double(input logic [15:0] w);
        is_double = (w[15:12] == 4'hC) || (w[15:6] == 10'h3B8) ||
            (w[15:9] == 7'h76) || (w[15:8] == 8'hEF);
    endfunction : is_double

    // ----------------------------------------------------------------
    // Phase counter
    // ----------------------------------------------------------------
    logic [1:0] phase_reg;
    logic [1:0] phase_next;
    wire cycle_start = (phase_reg == PHASE_RESET);
    wire cycle_end = (phase_reg == PHASES_PER_CYCLE_M1);
    assign phase_next = phase_reg + 2'h1;
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            phase_reg <= PHASE_RESET;
        end else if (clk_en_in) begin
            phase_reg <= phase_next;
        end
    end

    // ----------------------------------------------------------------
    // Combinational decode of the presented word
    // ----------------------------------------------------------------
    wire ift_fields_t dec;
    ift_state_t state_reg;
    logic first_double_reg;
    // The second word arrives during the second instruction cycle
    wire awaiting_second = (state_reg == IFT_ST_SECOND);
    wire ift_cat_t cat_w = classify(word_in);
    // lone second word is a no-operation
    wire lone_second = (word_in[15:12] == SECOND_WORD_TAG) && !awaiting_second;
    assign dec.category = cat_w;
    assign dec.opcode = word_in[15:OPC_LSB];
    assign dec.file_sel = word_in[7:0];
    assign dec.dest_to_file = (cat_w == IFT_CAT_BYTE) && word_in[D_POS];
    assign dec.use_bank_select = (cat_w == IFT_CAT_BYTE || cat_w == IFT_CAT_BIT) &&
        word_in[A_POS];
    assign dec.bit_num = (cat_w == IFT_CAT_BIT) ? word_in[BIT_LSB+2:BIT_LSB] : 3'h0;
    assign dec.literal = (cat_w == IFT_CAT_LIT || cat_w == IFT_CAT_CTRL) ?
        {4'h0, word_in[7:0]} : 12'h000;
    assign dec.file_select_pointer = (cat_w == IFT_CAT_LIT) ?
        word_in[FSR_LSB+1:FSR_LSB] : 2'h0;
    // fast mode and table mode from control words
    assign dec.fast_mode = (cat_w == IFT_CAT_CTRL) && word_in[S_POS];
    assign dec.table_pointer_mode = (cat_w == IFT_CAT_CTRL && word_in[15:2] == 14'h0002) ?
        ift_tbl_t'(word_in[MM_LSB+1:MM_LSB]) : IFT_TBL_NONE;
    assign dec.double_word = is_double(word_in) && !lone_second;
    assign dec.is_nop = lone_second || (word_in == 16'h0000);

    // ----------------------------------------------------------------
    // Instruction sequencer
    // ----------------------------------------------------------------
    ift_state_t state_next;
    logic [1:0] total_reg;
    logic [1:0] index_reg;
    logic [1:0] total_next;
    logic [1:0] index_next;
    wire take_word = cycle_start && word_valid_in &&
        (state_reg == IFT_ST_IDLE || state_reg == IFT_ST_EXTRA ||
         (state_reg == IFT_ST_FIRST && !first_double_reg));
    // single word: one cycle, two on taken or PC change
    wire [1:0] cycles_w = dec.double_word ?
        ((cond_true_in || pc_change_in) ? CYCLES_THREE : CYCLES_TWO) :
        ((cond_true_in || pc_change_in) ? CYCLES_TWO : CYCLES_ONE);

    // Next-state selection: steps at each cycle end, and a word taken at cycle start loads FIRST
    always_comb begin
        state_next = state_reg;
        total_next = total_reg;
        index_next = index_reg;
        case (state_reg)
            IFT_ST_IDLE, IFT_ST_FIRST, IFT_ST_SECOND, IFT_ST_EXTRA: begin
                if (cycle_end) begin
                    if (state_reg == IFT_ST_FIRST && first_double_reg) begin
                        state_next = IFT_ST_SECOND;
                        index_next = 2'h2;
                    end else if (index_reg < total_reg && state_reg != IFT_ST_IDLE) begin
                        state_next = IFT_ST_EXTRA;
                        index_next = index_reg + 2'h1;
                    end else begin
                        state_next = IFT_ST_IDLE;
                        index_next = 2'h0;
                        total_next = 2'h0;
                    end
                end
                if (take_word) begin
                    state_next = IFT_ST_FIRST;
                    total_next = cycles_w;
                    index_next = 2'h1;
                end
            end
            default: begin
                state_next = IFT_ST_IDLE;
            end
        endcase
    end

    // State and count registers
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            state_reg <= IFT_ST_IDLE;
            total_reg <= 2'h0;
            index_reg <= 2'h0;
            first_double_reg <= 1'b0;
        end else if (clk_en_in) begin
            state_reg <= state_next;
            total_reg <= total_next;
            index_reg <= index_next;
            if (take_word) begin
                first_double_reg <= dec.double_word;
            end else if (cycle_end) begin
                first_double_reg <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Output registers
    // ----------------------------------------------------------------
    ift_fields_t fields_reg;
    logic [15:0] operand2_reg;
    // Second word carries the remaining operand; its tag nibble is dropped
    wire take_second = cycle_start && word_valid_in && state_reg == IFT_ST_SECOND;
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            fields_reg <= '0;
            operand2_reg <= 16'h0000;
        end else if (clk_en_in) begin
            if (take_word) begin
                fields_reg <= dec;
            end
            if (take_second) begin
                operand2_reg <= {4'h0, word_in[11:0]};
            end
        end
    end
    assign fields_out = fields_reg;
    assign operand2_out = operand2_reg;
    wire busy_w = (state_reg != IFT_ST_IDLE);
    assign timing_out = {phase_reg, cycle_start, total_reg, index_reg, busy_w};
    // shadow use only in fast mode
    assign shadow_use_out = fields_reg.fast_mode;
    // bank select used only when access selector set
    assign bank_select_use_out = fields_reg.use_bank_select;
    assign write_working_register_out = (fields_reg.category == IFT_CAT_BYTE) &&
        !fields_reg.dest_to_file && !fields_reg.is_nop;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    chk_phase_wrap: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        clk_en_in && phase_reg == 2'h3 |=> phase_reg == 2'h0)
        else $error("phase did not wrap after four periods");
    chk_phase_step: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        clk_en_in |=> phase_reg == $past(phase_reg) + 2'h1)
        else $error("phase counter did not advance");
    chk_single_one: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        clk_en_in && take_word && !dec.double_word && !cond_true_in && !pc_change_in
        |=> total_reg == 2'h1)
        else $error("plain single word not one cycle");
    chk_single_two: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        clk_en_in && take_word && !dec.double_word && cond_true_in |=> total_reg == 2'h2)
        else $error("taken single word not two cycles");
    chk_double_two: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        clk_en_in && take_word && dec.double_word && !cond_true_in && !pc_change_in
        |=> total_reg == 2'h2)
        else $error("double word not two cycles");
    chk_branch_three: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        clk_en_in && take_word && dec.double_word && pc_change_in |=> total_reg == 2'h3)
        else $error("taken double branch not three cycles");
    chk_lone_nop: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        word_in[15:12] == 4'hF && state_reg == IFT_ST_IDLE |-> dec.is_nop && !dec.double_word)
        else $error("lone second word not a no-operation");
    chk_dest_working_register: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        clk_en_in && take_word && cat_w == IFT_CAT_BYTE && !word_in[9] && !dec.is_nop
        |=> write_working_register_out)
        else $error("destination zero did not select working register");
    chk_file_sel: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        clk_en_in && take_word |=> fields_out.file_sel == $past(word_in[7:0]))
        else $error("file selector not captured in full");

endmodule : ift_core

// *** test/tb_ift_core.sv ***
// Self-checking bench for the instruction format and timing core.
// Assumes the hand-over contract: first words taken at phase zero while idle,
// second words at the next phase zero, one word per instruction cycle.
`timescale 1ns/100ps
module tb_ift_core;
    import ift_pkg::*;
    logic clock_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic clk_en_in = 1'b1;
    logic word_valid_in = 1'b0;
    logic [15:0] word_in = 16'h0000;
    logic cond_true_in = 1'b0;
    logic pc_change_in = 1'b0;
    ift_fields_t fields_out;
    ift_timing_t timing_out;
    logic [15:0] operand2_out;
    logic shadow_use_out;
    logic bank_select_use_out;
    logic write_working_register_out;
    int err_total = 0;
    int checks_done = 0;
    int busy_cnt = 0;

    // ----------------------------------------------------------------
    // Clock, instance and busy counter
    // ----------------------------------------------------------------
    always #5 clock_in = ~clock_in;

    ift_core ift_core_inst (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .clk_en_in(clk_en_in),
        .word_valid_in(word_valid_in),
        .word_in(word_in),
        .cond_true_in(cond_true_in),
        .pc_change_in(pc_change_in),
        .fields_out(fields_out),
        .timing_out(timing_out),
        .operand2_out(operand2_out),
        .shadow_use_out(shadow_use_out),
        .bank_select_use_out(bank_select_use_out),
        .write_working_register_out(write_working_register_out)
    );

    // Counts rising edges seen busy; cleared on a falling edge so no race
    always @(posedge clock_in) begin
        if (timing_out.busy === 1'b1) busy_cnt <= busy_cnt + 1;
    end

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic conclude();
        $display("Totals: %0d checks, %0d mismatches", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : conclude

    task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp

    // Waits for a phase-zero slot (and idle for a first word), then offers one word
    task automatic send(input logic [15:0] w, input logic c, input logic p, input bit idle);
        int n;
        n = 0;
        @(negedge clock_in);
        while (!(timing_out.phase === 2'h0 && (!idle || timing_out.busy === 1'b0))) begin
            n++;
            if (n > 60) begin
                err_total++;
                conclude();
            end
            @(negedge clock_in);
        end
        if (idle) busy_cnt = 0;
        word_in = w;
        cond_true_in = c;
        pc_change_in = p;
        word_valid_in = 1'b1;
        @(negedge clock_in);
        word_valid_in = 1'b0;
    endtask : send

    // One whole instruction; judges its cycle count and the busy length
    task automatic run(input string name, input logic [15:0] w1, input logic [15:0] w2,
                       input bit dbl, input logic c, input logic p, input int ncyc);
        int n;
        n = 0;
        send(w1, c, p, 1'b1);
        cmp({name, " cycles_total"}, 16'(ncyc), 16'(timing_out.cycles_total));
        if (dbl) send(w2, c, p, 1'b0);
        while (timing_out.busy === 1'b1 && n < 40) begin
            @(negedge clock_in);
            n++;
        end
        if (n >= 40) begin
            err_total++;
            conclude();
        end
        // Four oscillator periods per instruction cycle
        // Busy rises after the taking edge, so the first period is not seen busy
        cmp({name, " busy clocks"}, 16'(4 * ncyc - 1), 16'(busy_cnt));
    endtask : run

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_phase();
        logic [1:0] ph;
        ph = 2'h0;
        for (int i = 0; i < 9; i++) begin
            cmp("phase", 16'(ph), 16'(timing_out.phase));
            cmp("cycle_start", 16'(ph == 2'h0), 16'(timing_out.cycle_start));
            ph = ph + 2'h1;
            @(negedge clock_in);
        end
        // Enable low must freeze the counter
        clk_en_in = 1'b0;
        ph = timing_out.phase;
        repeat (3) @(negedge clock_in);
        cmp("phase frozen", 16'(ph), 16'(timing_out.phase));
        clk_en_in = 1'b1;
        $display("test phase done");
    endtask : t_phase

    task automatic t_byte();
        logic [15:0] w [4] = '{16'h26AB, 16'h2534, 16'h24FF, 16'h2700};
        for (int i = 0; i < 4; i++) begin
            run("byte", w[i], 16'h0000, 1'b0, 1'(i == 1), 1'b0, 1 + (i == 1));
            cmp("file_sel", 16'(w[i][7:0]), 16'(fields_out.file_sel));
            cmp("dest_to_file", 16'(w[i][9]), 16'(fields_out.dest_to_file));
            cmp("working_register", 16'(!w[i][9]), 16'(write_working_register_out));
            cmp("bank", 16'(w[i][8]), 16'(bank_select_use_out));
        end
        $display("test byte done");
    endtask : t_byte

    task automatic t_bit();
        run("bit", 16'h8B5A, 16'h0000, 1'b0, 1'b0, 1'b0, 1);
        cmp("bit_num", 16'h0005, 16'(fields_out.bit_num));
        cmp("bit file_sel", 16'h005A, 16'(fields_out.file_sel));
        cmp("bit access", 16'h0001, 16'(fields_out.use_bank_select));
        $display("test bit done");
    endtask : t_bit

    task automatic t_ctrl();
        run("ret fast", 16'h0013, 16'h0000, 1'b0, 1'b0, 1'b1, 2);
        cmp("fast_mode", 16'h0001, 16'(fields_out.fast_mode));
        cmp("shadow", 16'h0001, 16'(shadow_use_out));
        run("ret slow", 16'h0012, 16'h0000, 1'b0, 1'b0, 1'b1, 2);
        cmp("shadow off", 16'h0000, 16'(shadow_use_out));
        for (int i = 0; i < 4; i++) begin
            run("table", 16'h0008 + 16'(i), 16'h0000, 1'b0, 1'b0, 1'b0, 1);
            cmp("table mode", 16'(i), 16'(fields_out.table_pointer_mode));
        end
        $display("test ctrl done");
    endtask : t_ctrl

    task automatic t_double();
        run("load ptr", 16'hEE27, 16'hF0AB, 1'b1, 1'b0, 1'b0, 2);
        cmp("pointer", 16'h0002, 16'(fields_out.file_select_pointer));
        cmp("double", 16'h0001, 16'(fields_out.double_word));
        cmp("operand2", 16'h00AB, operand2_out);
        run("move", 16'hC123, 16'hF456, 1'b1, 1'b0, 1'b0, 2);
        cmp("move operand2", 16'h0456, operand2_out);
        run("jump taken", 16'hEF12, 16'hF345, 1'b1, 1'b0, 1'b1, 3);
        run("lone second", 16'hF123, 16'h0000, 1'b0, 1'b0, 1'b0, 1);
        cmp("is_nop", 16'h0001, 16'(fields_out.is_nop));
        cmp("nop working_register", 16'h0000, 16'(write_working_register_out));
        $display("test double done");
    endtask : t_double

    // Reset in the middle of a double word must clear everything
    task automatic t_reset();
        send(16'hC321, 1'b0, 1'b0, 1'b1);
        rst_n_in = 1'b0;
        @(negedge clock_in);
        cmp("rst busy", 16'h0000, 16'(timing_out.busy));
        cmp("rst phase", 16'h0000, 16'(timing_out.phase));
        cmp("rst fields", 16'h0001, 16'(fields_out === '0));
        rst_n_in = 1'b1;
        run("after rst", 16'h26AB, 16'h0000, 1'b0, 1'b0, 1'b0, 1);
        $display("test reset done");
    endtask : t_reset

    initial begin
        repeat (12) @(negedge clock_in);
        cmp("reset phase", 16'h0000, 16'(timing_out.phase));
        rst_n_in = 1'b1;
        t_phase();
        t_byte();
        t_bit();
        t_ctrl();
        t_double();
        t_reset();
        conclude();
    end
endmodule : tb_ift_core
